//--- tfsr_pkg.sv
// constants, state codes and carrier types for the timed fault and status bank
`default_nettype none
package tfsr_pkg;
  // management command codes
  localparam logic [7:0] TFSR_CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] TFSR_CMD_TON_RESP = 8'h63;
  localparam logic [7:0] TFSR_CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] TFSR_CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] TFSR_CMD_STATUS_VOUT = 8'h7a;
  // response register fields
  localparam int TFSR_ACT_HI = 7;
  localparam int TFSR_ACT_LO = 6;
  localparam int TFSR_RETRY_HI = 5;
  localparam int TFSR_RETRY_LO = 3;
  localparam logic [2:0] TFSR_DELAY_FIXED = 3'h0;
  localparam logic [7:0] TFSR_TON_RESP_RST = 8'h00;
  // summary word bit positions
  localparam int TFSR_W_VOUT = 15;
  localparam int TFSR_W_INPUT = 13;
  localparam int TFSR_W_MFR = 12;
  localparam int TFSR_W_PNG = 11;
  localparam int TFSR_W_BUSY = 7;
  localparam int TFSR_W_OFF = 6;
  localparam int TFSR_W_VOUT_OV = 5;
  localparam int TFSR_W_VIN_UV = 3;
  localparam int TFSR_W_TEMP = 2;
  localparam int TFSR_W_CML = 1;
  localparam int TFSR_W_HIGH = 0;
  // output-voltage status bit positions
  localparam int TFSR_V_OV_F = 7;
  localparam int TFSR_V_OV_W = 6;
  localparam int TFSR_V_UV_W = 5;
  localparam int TFSR_V_UV_F = 4;
  localparam int TFSR_V_MAX = 3;
  localparam int TFSR_V_TON = 2;
  localparam logic [7:0] TFSR_VOUT_MASK = 8'hfc;
  localparam logic [15:0] TFSR_RETRY_RST = 16'h0000;

  typedef enum logic [3:0] {
    TFSR_OFF = 4'b0001,
    TFSR_ON = 4'b0010,
    TFSR_RETRY = 4'b0100,
    TFSR_LATCHED = 4'b1000
  } tfsr_state_t;

  // one-cycle fault and warning events from the monitors
  typedef struct packed {
    logic ton_max_fault;
    logic vout_ov_fault;
    logic vout_ov_warn;
    logic vout_uv_warn;
    logic vout_uv_fault;
    logic vout_max_fault;
    logic vin_uv_fault;
    logic input_fault;
    logic temp_fault;
    logic cml_fault;
    logic mfr_fault;
    logic other_shutdown;
  } tfsr_events_t;

  // decoded command from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } tfsr_cmd_t;

  typedef struct packed {
    tfsr_state_t fsm;
    logic [15:0] retry_cnt;
    logic [7:0] ton_resp;
    logic [7:0] vout;
    logic busy;
    logic vout_ov;
    logic vin_uv;
    logic temp;
    logic cml;
    logic input_f;
    logic mfr;
    logic alert;
    logic [15:0] rd_data;
    logic rd_valid;
    logic ctrl_s1;
    logic ctrl_s2;
    logic bias_s1;
    logic bias_s2;
    logic cmd_on_q;
  } tfsr_regs_t;
endpackage : tfsr_pkg
`default_nettype wire

//--- tfsr_bank.sv
// turn-on timeout fault response and summary status register bank
`default_nettype none

module tfsr_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // pins from outside the clock domain
  input wire logic ctrl_pin,
  input wire logic bias_sense_pin,
  // open-drain alert pin
  output logic alert_line_n_o,
  output logic alert_line_n_oe,
  // command port from the serial front end
  input wire tfsr_pkg::tfsr_cmd_t cmd,
  input wire logic dev_busy,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // channel control and monitor inputs
  input wire logic operation_on,
  input wire logic power_good,
  input wire logic [15:0] retry_interval,
  input wire tfsr_pkg::tfsr_events_t ev,
  // channel output
  output logic chan_enable
);
  import tfsr_pkg::*;

  tfsr_regs_t s;
  tfsr_regs_t next_s;

  // summary word from the latched bits and live channel state
  function automatic logic [15:0] tfsr_word(input tfsr_regs_t r, input logic pg);
    logic [15:0] w;
    w = 16'h0000; // unsupported bits 14, 10, 9, 8, 4 stay zero
    w[TFSR_W_VOUT] = |r.vout;
    w[TFSR_W_INPUT] = r.input_f;
    w[TFSR_W_MFR] = r.mfr;
    w[TFSR_W_PNG] = ~pg;
    w[TFSR_W_BUSY] = r.busy;
    w[TFSR_W_OFF] = (r.fsm != TFSR_ON); // off for any reason
    w[TFSR_W_VOUT_OV] = r.vout_ov;
    w[TFSR_W_VIN_UV] = r.vin_uv;
    w[TFSR_W_TEMP] = r.temp;
    w[TFSR_W_CML] = r.cml;
    // summary of anything only the upper byte explains
    w[TFSR_W_HIGH] = (|r.vout) | r.input_f | r.mfr | ~pg;
    return w;
  endfunction : tfsr_word

  logic cmd_on;
  logic toggle;
  logic shut_act;
  logic retry_on;
  logic clr;
  logic accept;
  logic [15:0] word;

  // channel command, toggle detection and response decode
  always_comb begin
    cmd_on = s.ctrl_s2 & operation_on & s.bias_s2;
    toggle = cmd_on != s.cmd_on_q;
    // action 00 runs on; 01 and 1x both shut down
    shut_act = s.ton_resp[TFSR_ACT_HI] | s.ton_resp[TFSR_ACT_LO];
    retry_on = |s.ton_resp[TFSR_RETRY_HI:TFSR_RETRY_LO];
    accept = (cmd.wr | cmd.rd) & ~dev_busy;
    clr = (accept & cmd.wr & (cmd.code == TFSR_CMD_CLEAR_FAULTS)) | toggle;
    word = tfsr_word(s, power_good);
  end

  // whole next state in one place
  always_comb begin
    next_s = s;
    next_s.rd_valid = 1'b0;
    // two-stage synchronisers for the pins
    next_s.ctrl_s1 = ctrl_pin;
    next_s.ctrl_s2 = s.ctrl_s1;
    next_s.bias_s1 = bias_sense_pin;
    next_s.bias_s2 = s.bias_s1;
    next_s.cmd_on_q = cmd_on;

    // channel sequencing; shutdown has no delay stage at all
    unique case (s.fsm)
      TFSR_OFF: begin
        if (cmd_on) begin
          next_s.fsm = TFSR_ON;
        end
      end
      TFSR_ON: begin
        if (!cmd_on) begin
          next_s.fsm = TFSR_OFF;
        end else if (ev.other_shutdown) begin
          next_s.fsm = TFSR_LATCHED;
        end else if (ev.ton_max_fault && shut_act) begin
          if (retry_on) begin
            next_s.fsm = TFSR_RETRY;
            next_s.retry_cnt = retry_interval;
          end else begin
            next_s.fsm = TFSR_LATCHED;
          end
        end
      end
      TFSR_RETRY: begin
        // retries end on command off or another shutdown fault
        if (!cmd_on) begin
          next_s.fsm = TFSR_OFF;
        end else if (ev.other_shutdown) begin
          next_s.fsm = TFSR_LATCHED;
        end else if (s.retry_cnt == 16'h0000) begin
          next_s.fsm = TFSR_ON;
        end else begin
          next_s.retry_cnt = s.retry_cnt - 16'h0001;
        end
      end
      TFSR_LATCHED: begin
        // only a toggle or bias loss leaves here; clear faults does not
        if (toggle) begin
          next_s.fsm = TFSR_OFF;
        end
      end
    endcase

    // latched status: clear first, so a same-cycle event still sets
    if (clr) begin
      next_s.vout = 8'h00;
      next_s.busy = 1'b0;
      next_s.vout_ov = 1'b0;
      next_s.vin_uv = 1'b0;
      next_s.temp = 1'b0;
      next_s.cml = 1'b0;
      next_s.input_f = 1'b0;
      next_s.mfr = 1'b0;
    end
    // each fault and warning except other_shutdown sets its bits; the timeout only while on
    if (ev.vout_ov_fault) begin
      next_s.vout[TFSR_V_OV_F] = 1'b1;
      next_s.vout_ov = 1'b1;
    end
    if (ev.vout_ov_warn) begin
      next_s.vout[TFSR_V_OV_W] = 1'b1;
    end
    if (ev.vout_uv_warn) begin
      next_s.vout[TFSR_V_UV_W] = 1'b1;
    end
    if (ev.vout_uv_fault) begin
      next_s.vout[TFSR_V_UV_F] = 1'b1;
    end
    if (ev.vout_max_fault) begin
      next_s.vout[TFSR_V_MAX] = 1'b1;
    end
    // timeout flags even when the action lets the channel run
    if (ev.ton_max_fault && s.fsm == TFSR_ON) begin
      next_s.vout[TFSR_V_TON] = 1'b1;
    end
    if (ev.vin_uv_fault) begin
      next_s.vin_uv = 1'b1;
      next_s.input_f = 1'b1;
    end
    if (ev.input_fault) begin
      next_s.input_f = 1'b1;
    end
    if (ev.temp_fault) begin
      next_s.temp = 1'b1;
    end
    if (ev.cml_fault) begin
      next_s.cml = 1'b1;
    end
    if (ev.mfr_fault) begin
      next_s.mfr = 1'b1;
    end
    // a command that arrives while busy is dropped and flagged
    if ((cmd.wr | cmd.rd) && dev_busy) begin
      next_s.busy = 1'b1;
    end

    // command decode
    if (accept && cmd.wr) begin
      unique case (cmd.code)
        TFSR_CMD_TON_RESP: begin
          // delay bits cannot be written
          next_s.ton_resp = {cmd.wdata[TFSR_ACT_HI:TFSR_RETRY_LO], TFSR_DELAY_FIXED};
        end
        TFSR_CMD_CLEAR_FAULTS: begin
          next_s.ton_resp = s.ton_resp;
        end
        default: begin
          next_s.cml = 1'b1; // unwritable or unknown code
        end
      endcase
    end
    if (accept && cmd.rd) begin
      next_s.rd_valid = 1'b1;
      unique case (cmd.code)
        TFSR_CMD_TON_RESP: begin
          next_s.rd_data = {8'h00, s.ton_resp};
        end
        TFSR_CMD_STATUS_BYTE: begin
          next_s.rd_data = {8'h00, word[7:0]}; // same bits as the word low byte
        end
        TFSR_CMD_STATUS_WORD: begin
          next_s.rd_data = word;
        end
        TFSR_CMD_STATUS_VOUT: begin
          next_s.rd_data = {8'h00, s.vout & TFSR_VOUT_MASK};
        end
        default: begin
          next_s.rd_data = 16'h0000;
          next_s.cml = 1'b1;
        end
      endcase
    end

    // bias loss forgets faults and the latched-off state
    if (!s.bias_s2) begin
      next_s.fsm = TFSR_OFF;
      next_s.retry_cnt = TFSR_RETRY_RST;
      next_s.vout = 8'h00;
      next_s.busy = 1'b0;
      next_s.vout_ov = 1'b0;
      next_s.vin_uv = 1'b0;
      next_s.temp = 1'b0;
      next_s.cml = 1'b0;
      next_s.input_f = 1'b0;
      next_s.mfr = 1'b0;
    end

    // alert follows any latched bit, so clear faults releases it
    next_s.alert = (|next_s.vout) | next_s.busy | next_s.vout_ov | next_s.vin_uv
                 | next_s.temp | next_s.cml | next_s.input_f | next_s.mfr;
  end

  // state register; configuration survives bias loss, only reset clears it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
      s.fsm <= TFSR_OFF;
      s.ton_resp <= TFSR_TON_RESP_RST;
      s.retry_cnt <= TFSR_RETRY_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops except chan_enable, decoded from the state register, and alert_line_n_o, tied low; the pin only ever pulls low
  assign alert_line_n_o = 1'b0;
  assign alert_line_n_oe = s.alert;
  assign rd_data = s.rd_data;
  assign rd_valid = s.rd_valid;
  assign chan_enable = (s.fsm == TFSR_ON);
endmodule : tfsr_bank
`default_nettype wire

//--- tfsr_bank_asserts.sv
// concurrent checks on the bank's ports
`default_nettype none
module tfsr_bank_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command port
  input wire tfsr_pkg::tfsr_cmd_t cmd,
  input wire logic dev_busy,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  // alert and channel
  input wire logic alert_line_n_o,
  input wire logic alert_line_n_oe,
  input wire logic operation_on,
  input wire tfsr_pkg::tfsr_events_t ev,
  input wire logic chan_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  import tfsr_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rd; cmd.rd && !dev_busy |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_busy; cmd.rd && dev_busy |=> !rd_valid && alert_line_n_oe; endproperty
  a_busy: assert property (p_busy) else $error("busy read not flagged");
  property p_od; alert_line_n_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("alert pin drives high");
  property p_ton; chan_enable && ev.ton_max_fault |=> alert_line_n_oe; endproperty
  a_ton: assert property (p_ton) else $error("timeout gave no alert");
  property p_shut; chan_enable && ev.other_shutdown |=> !chan_enable; endproperty
  a_shut: assert property (p_shut) else $error("shutdown ignored");
  property p_on; $rose(chan_enable) |-> $past(operation_on); endproperty
  a_on: assert property (p_on) else $error("enabled without on command");
  property p_clr;
    cmd.wr && !cmd.rd && !dev_busy && cmd.code == TFSR_CMD_CLEAR_FAULTS && ev == '0 |=> !alert_line_n_oe;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left alert");
  property p_zero; rd_valid |-> rd_data[14] == 1'b0 && rd_data[10:8] == 3'h0; endproperty
  a_zero: assert property (p_zero) else $error("unsupported bit set");
  property p_dly;
    rd_valid && $past(cmd.rd) && $past(cmd.code) == TFSR_CMD_TON_RESP |-> rd_data[2:0] == 3'h0;
  endproperty
  a_dly: assert property (p_dly) else $error("delay field not zero");
endmodule : tfsr_bank_asserts
bind tfsr_bank tfsr_bank_asserts chk (.core_clk(core_clk), .reset(reset), .cmd(cmd), .dev_busy(dev_busy),
  .rd_data(rd_data), .rd_valid(rd_valid), .alert_line_n_o(alert_line_n_o), .alert_line_n_oe(alert_line_n_oe),
  .operation_on(operation_on), .ev(ev), .chan_enable(chan_enable));
`default_nettype wire

//--- tfsr_host.sv
// management host model on the command port
`default_nettype none
module tfsr_host (
  // clock
  input wire logic core_clk,
  // command port
  output var tfsr_pkg::tfsr_cmd_t cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  import tfsr_pkg::*;
  // idle until the first request
  initial cmd = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic v);
    @(posedge core_clk);
    cmd <= '{wr: w, rd: !w, code: c, wdata: d};
    @(posedge core_clk);
    // released fields scrambled so stale values never look valid
    cmd <= '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
    // the answer stands for the cycle after the taking edge; sample it settled
    #1;
    q = rd_data;
    v = rd_valid;
  endtask : xfer
endmodule : tfsr_host
`default_nettype wire

//--- tfsr_bank_tb_top.sv
// self-checking bench for the timed fault and status bank
`default_nettype none
module tfsr_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tfsr_pkg::*;
  // stimulus and observed signals
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ctrl_pin = 1'b1;
  logic bias_sense_pin = 1'b1;
  logic dev_busy = 1'b0;
  logic operation_on = 1'b0;
  logic power_good = 1'b0;
  logic [15:0] retry_interval = 16'h0008;
  tfsr_events_t ev = '0;
  tfsr_cmd_t cmd;
  logic alert_line_n_o, alert_line_n_oe, rd_valid, chan_enable, v;
  logic [15:0] rd_data, q;
  int n_errors = 0;
  int comparisons = 0;
  // 40 MHz clock
  initial forever #12.5 core_clk = ~core_clk;
  tfsr_bank dut (.core_clk(core_clk), .reset(reset), .ctrl_pin(ctrl_pin), .bias_sense_pin(bias_sense_pin),
    .alert_line_n_o(alert_line_n_o), .alert_line_n_oe(alert_line_n_oe), .cmd(cmd), .dev_busy(dev_busy),
    .rd_data(rd_data), .rd_valid(rd_valid), .operation_on(operation_on), .power_good(power_good),
    .retry_interval(retry_interval), .ev(ev), .chan_enable(chan_enable));
  tfsr_host host (.core_clk(core_clk), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // short bus and timing helpers
  task automatic rd(input logic [7:0] c);
    host.xfer(1'b0, c, 16'h0000, q, v);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic pulse(input tfsr_events_t e);
    @(posedge core_clk);
    ev <= e;
    @(posedge core_clk);
    ev <= '0;
    #1;
  endtask : pulse
  // on-request toggle through the pin or the on/off command
  task automatic cycle_on(input logic pin);
    @(posedge core_clk);
    {ctrl_pin, operation_on} <= pin ? 2'b01 : 2'b10;
    tick(5);
    @(posedge core_clk);
    {ctrl_pin, operation_on} <= 2'b11;
    tick(5);
  endtask : cycle_on
  task automatic t_idle;
    rd(TFSR_CMD_TON_RESP);
    chk(q, 16'h0000);
    rd(TFSR_CMD_STATUS_WORD);
    chk(q, 16'h0841);
    rd(TFSR_CMD_STATUS_BYTE);
    chk(q, 16'h0041);
    @(posedge core_clk);
    {operation_on, power_good} <= 2'b11;
    tick(5);
    chk({15'h0, chan_enable}, 16'h0001);
    rd(TFSR_CMD_STATUS_WORD);
    chk(q, 16'h0000);
  endtask : t_idle
  // timeout with each action code and a retry setting
  task automatic t_ton(input logic [1:0] act, input logic [2:0] rty);
    logic sd;
    logic lat;
    sd = (act != 2'b00);
    lat = sd && (rty == 3'b000);
    host.xfer(1'b1, TFSR_CMD_TON_RESP, {8'h00, act, rty, 3'b111}, q, v);
    rd(TFSR_CMD_TON_RESP);
    chk(q, {8'h00, act, rty, 3'b000});
    pulse(tfsr_events_t'(12'h800));
    chk({15'h0, chan_enable}, {15'h0, !sd});
    chk({15'h0, alert_line_n_oe}, 16'h0001);
    tick(8);
    chk({15'h0, chan_enable}, {15'h0, !sd});
    tick(3);
    chk({15'h0, chan_enable}, {15'h0, !lat});
    rd(TFSR_CMD_STATUS_VOUT);
    chk(q, 16'h0004);
    rd(TFSR_CMD_STATUS_WORD);
    chk(q, {8'h80, lat ? 8'h41 : 8'h01});
    host.xfer(1'b1, TFSR_CMD_CLEAR_FAULTS, 16'h0000, q, v);
    rd(TFSR_CMD_STATUS_VOUT);
    chk(q, 16'h0000);
    chk({14'h0, alert_line_n_oe, chan_enable}, {15'h0, !lat});
    cycle_on(act[0]);
    chk({15'h0, chan_enable}, 16'h0001);
  endtask : t_ton
  // busy drop, unknown code, every other event, shutdown, bias loss
  task automatic t_mix;
    @(posedge core_clk);
    dev_busy <= 1'b1;
    rd(TFSR_CMD_STATUS_WORD);
    chk({15'h0, v}, 16'h0000);
    @(posedge core_clk);
    dev_busy <= 1'b0;
    rd(8'h55);
    chk(q, 16'h0000);
    pulse(tfsr_events_t'(12'h7fe));
    rd(TFSR_CMD_STATUS_WORD);
    chk(q, 16'hb0af);
    rd(TFSR_CMD_STATUS_BYTE);
    chk(q, 16'h00af);
    rd(TFSR_CMD_STATUS_VOUT);
    chk(q, 16'h00f8);
    pulse(tfsr_events_t'(12'h001));
    chk({15'h0, chan_enable}, 16'h0000);
    @(posedge core_clk);
    bias_sense_pin <= 1'b0;
    tick(5);
    chk({15'h0, alert_line_n_oe}, 16'h0000);
    @(posedge core_clk);
    bias_sense_pin <= 1'b1;
    tick(6);
    chk({15'h0, chan_enable}, 16'h0001);
  endtask : t_mix
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    tick(3);
    t_idle;
    t_ton(2'b00, 3'b000);
    t_ton(2'b01, 3'b000);
    t_ton(2'b10, 3'b101);
    t_ton(2'b11, 3'b001);
    t_mix;
    end_sim;
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    end_sim;
  end
endmodule : tfsr_bank_tb_top
`default_nettype wire
